// file: include/sram_pkg.sv
// Shared constants and types for the synchronous burst SRAM core.
package sram_pkg;

  // Narrow organization: 2M words of 18 bits.
  localparam int X18_ADDR_W = 21;
  localparam int X18_DATA_W = 18;

  // Wide organization: 1M words of 36 bits.
  localparam int X36_ADDR_W = 20;
  localparam int X36_DATA_W = 36;

  // Each byte lane carries eight data bits plus one parity bit.
  localparam int LANE_W = 9;

  // The internal burst counter covers the two lowest address bits.
  localparam int BURST_W = 2;

  // Mode pin levels seen when a mode pin is left unconnected.
  localparam logic ORDER_SEL_DEFAULT_N = 1'h1;
  localparam logic FLOW_SEL_DEFAULT_N  = 1'h1;
  localparam logic DESEL_SINGLE        = 1'h1;
  localparam logic DESEL_DEFAULT       = DESEL_SINGLE;

  // Sleep is inactive out of reset.
  localparam logic SLEEP_IDLE = 1'h0;

  // Operation captured on one rising edge.
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE,
    OP_DESEL
  } op_t;

endpackage : sram_pkg

// file: include/burst_cnt_if.sv
// Control and result signals between the core and its burst address counter.
`timescale 1ns/1ps
interface burst_cnt_if;
  import sram_pkg::*;

  logic               load;
  logic               step;
  logic [BURST_W-1:0] preset;
  logic               linear;
  logic [BURST_W-1:0] low_nxt;

  modport ctrl (output load, output step, output preset, output linear, input low_nxt);
  modport cnt  (input load, input step, input preset, input linear, output low_nxt);

endinterface : burst_cnt_if

// file: src/burst_addr_counter.sv
// Two-bit burst address counter with linear and interleaved order.
`timescale 1ns/1ps
module burst_addr_counter (
  input wire logic  clk,
  input wire logic  rst_n,
  burst_cnt_if.cnt  bus
);
  import sram_pkg::*;

  logic [BURST_W-1:0] base_ff;
  logic [BURST_W-1:0] nxt_base;
  logic [BURST_W-1:0] seq_ff;
  logic [BURST_W-1:0] nxt_seq;

  // Linear order adds and wraps inside the group; interleaved order flips bits.
  function automatic logic [BURST_W-1:0] order_addr(input logic               lin,
                                                    input logic [BURST_W-1:0] base,
                                                    input logic [BURST_W-1:0] seq);
    return lin ? BURST_W'(base + seq) : (base ^ seq);
  endfunction : order_addr

  always_comb begin
    nxt_base = base_ff;
    nxt_seq  = seq_ff;
    if (bus.load) begin
      nxt_base = bus.preset;
      nxt_seq  = '0;
    end else if (bus.step) begin
      nxt_seq = BURST_W'(seq_ff + 1'h1);
    end
    bus.low_nxt = order_addr(bus.linear, nxt_base, nxt_seq);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_ff <= '0;
      seq_ff  <= '0;
    end else begin
      base_ff <= nxt_base;
      seq_ff  <= nxt_seq;
    end
  end

endmodule : burst_addr_counter

// file: src/sync_burst_sram_core.sv
// Synchronous burst SRAM core with burst counter, read modes and deselect modes.
`timescale 1ns/1ps
module sync_burst_sram_core #(
  parameter bit WIDE_ORG = 1'b0,
  parameter int ADDR_W   = WIDE_ORG ? sram_pkg::X36_ADDR_W : sram_pkg::X18_ADDR_W,
  parameter int DATA_W   = WIDE_ORG ? sram_pkg::X36_DATA_W : sram_pkg::X18_DATA_W,
  parameter int LANES    = DATA_W / sram_pkg::LANE_W
) (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] DQ_IN,
  output logic      [DATA_W-1:0] DQ_OUT,
  output logic                   DQ_OE_N,
  input  wire logic              CHIP_SEL1_N,
  input  wire logic              CHIP_SEL2,
  input  wire logic              CHIP_SEL3_N,
  input  wire logic              PROC_ADDR_STROBE_N,
  input  wire logic              CTRL_ADDR_STROBE_N,
  input  wire logic              BURST_ADVANCE_N,
  input  wire logic              BYTE_WRITE_EN_N,
  input  wire logic [LANES-1:0]  BYTE_LANE_SEL_N,
  input  wire logic              ALL_BYTES_WRITE_N,
  input  wire logic              OUT_EN_N,
  input  wire logic              SLEEP_REQ,
  input  logic                   LINEAR_ORDER_SEL_N = sram_pkg::ORDER_SEL_DEFAULT_N,
  input  logic                   FLOWTHROUGH_SEL_N  = sram_pkg::FLOW_SEL_DEFAULT_N,
  input  logic                   DESELECT_MODE_SEL  = sram_pkg::DESEL_DEFAULT
);
  import sram_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  // Storage has no reset, so contents survive reset and sleep alike.
  logic [DATA_W-1:0] mem [0:DEPTH-1];

  // Mode pins and sleep are quasi-static pins and are synchronized.
  logic order_meta_ff;
  logic order_sync_ff;
  logic flow_meta_ff;
  logic flow_sync_ff;
  logic desel_meta_ff;
  logic desel_sync_ff;
  logic sleep_meta_ff;
  logic sleep_sync_ff;

  // Command decode.
  logic                     cs_ok;
  logic                     start_proc;
  logic                     start_ctrl;
  logic [LANES-1:0]         lanes;
  logic                     wr_any;
  op_t                      op;
  logic [ADDR_W-1:0]        acc_addr;
  logic [DATA_W-1:0]        rd_word;

  // Burst state.
  logic                     active_ff;
  logic                     nxt_active;
  logic [ADDR_W-1:BURST_W]  addr_hi_ff;
  logic [ADDR_W-1:BURST_W]  nxt_addr_hi;

  // Read pipeline and output drive.
  op_t                      op1_ff;
  op_t                      nxt_op1;
  logic [DATA_W-1:0]        pipe_data_ff;
  logic [DATA_W-1:0]        nxt_pipe_data;
  logic [DATA_W-1:0]        dout_ff;
  logic [DATA_W-1:0]        nxt_dout;
  logic                     drive_ff;
  logic                     nxt_drive;
  logic                     read_due;
  logic                     off_due;

  burst_cnt_if cnt_bus ();

  burst_addr_counter u_counter (
    .clk   (CLK),
    .rst_n (RST_N),
    .bus   (cnt_bus.cnt)
  );

  // Lane write mask: global write covers all lanes, byte write only selected ones.
  function automatic logic [LANES-1:0] write_lanes(input logic             gw_n,
                                                   input logic             bw_n,
                                                   input logic [LANES-1:0] sel_n);
    logic [LANES-1:0] mask;
    mask = '0;
    if (!gw_n) begin
      mask = '1;
    end else if (!bw_n) begin
      mask = ~sel_n;
    end
    return mask;
  endfunction : write_lanes

  // Mode pin synchronizers reset to the unconnected levels of each pin; sleep resets to idle.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      order_meta_ff <= ORDER_SEL_DEFAULT_N;
      order_sync_ff <= ORDER_SEL_DEFAULT_N;
      flow_meta_ff  <= FLOW_SEL_DEFAULT_N;
      flow_sync_ff  <= FLOW_SEL_DEFAULT_N;
      desel_meta_ff <= DESEL_DEFAULT;
      desel_sync_ff <= DESEL_DEFAULT;
      sleep_meta_ff <= SLEEP_IDLE;
      sleep_sync_ff <= SLEEP_IDLE;
    end else begin
      order_meta_ff <= LINEAR_ORDER_SEL_N;
      order_sync_ff <= order_meta_ff;
      flow_meta_ff  <= FLOWTHROUGH_SEL_N;
      flow_sync_ff  <= flow_meta_ff;
      desel_meta_ff <= DESELECT_MODE_SEL;
      desel_sync_ff <= desel_meta_ff;
      sleep_meta_ff <= SLEEP_REQ;
      sleep_sync_ff <= sleep_meta_ff;
    end
  end

  // The processor strobe is only honoured while the first chip select is low,
  // whereas the controller strobe is always honoured and may deselect.
  always_comb begin
    cs_ok      = !CHIP_SEL1_N && CHIP_SEL2 && !CHIP_SEL3_N;
    start_proc = !PROC_ADDR_STROBE_N && !CHIP_SEL1_N;
    start_ctrl = !CTRL_ADDR_STROBE_N;
    lanes      = write_lanes(ALL_BYTES_WRITE_N, BYTE_WRITE_EN_N, BYTE_LANE_SEL_N);
    wr_any     = |lanes;
  end

  // Command decode for the current edge; every address arrives fresh or from
  // the counter in the same cycle, so back-to-back loads cost nothing.
  always_comb begin
    op              = OP_IDLE;
    nxt_active      = active_ff;
    nxt_addr_hi     = addr_hi_ff;
    cnt_bus.load    = 1'b0;
    cnt_bus.step    = 1'b0;
    cnt_bus.preset  = ADDR[BURST_W-1:0];
    cnt_bus.linear  = !order_sync_ff;
    if (!sleep_sync_ff) begin
      if (start_proc || start_ctrl) begin
        if (!cs_ok) begin
          op         = OP_DESEL;
          nxt_active = 1'b0;
        end else begin
          cnt_bus.load = 1'b1;
          nxt_addr_hi  = ADDR[ADDR_W-1:BURST_W];
          nxt_active   = 1'b1;
          // A processor-strobe start is always a read.
          op = (!start_proc && wr_any) ? OP_WRITE : OP_READ;
        end
      end else if (active_ff) begin
        cnt_bus.step = !BURST_ADVANCE_N;
        op           = wr_any ? OP_WRITE : OP_READ;
      end
    end
    acc_addr = {nxt_addr_hi, cnt_bus.low_nxt};
    rd_word  = mem[acc_addr];
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      active_ff  <= 1'b0;
      addr_hi_ff <= '0;
    end else begin
      active_ff  <= nxt_active;
      addr_hi_ff <= nxt_addr_hi;
    end
  end

  // Writes land on the very edge that samples them; no later cycle is needed.
  always_ff @(posedge CLK) begin
    if (op == OP_WRITE) begin
      for (int l = 0; l < LANES; l++) begin
        if (lanes[l]) begin
          mem[acc_addr][l*LANE_W +: LANE_W] <= DQ_IN[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Flow-through loads the output flop from the array on the capture edge;
  // pipelined mode passes through one more register stage first.
  always_comb begin
    nxt_op1       = op;
    nxt_pipe_data = (op == OP_READ) ? rd_word : pipe_data_ff;
    nxt_dout      = dout_ff;
    if (!flow_sync_ff) begin
      if (op == OP_READ) begin
        nxt_dout = rd_word;
      end
    end else if (op1_ff == OP_READ) begin
      nxt_dout = pipe_data_ff;
    end
  end

  // Drive control: a pending read turns drive on at its data edge. A write,
  // or a deselect after its mode's latency, turns it off; otherwise it holds.
  always_comb begin
    read_due = !flow_sync_ff ? (op == OP_READ) : (op1_ff == OP_READ);
    off_due  = (op == OP_WRITE) || (op1_ff == OP_DESEL);
    if (desel_sync_ff == DESEL_SINGLE && op == OP_DESEL) begin
      off_due = 1'b1;
    end
    if (read_due) begin
      nxt_drive = 1'b1;
    end else if (off_due) begin
      nxt_drive = 1'b0;
    end else begin
      nxt_drive = drive_ff;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      op1_ff       <= OP_IDLE;
      pipe_data_ff <= '0;
      dout_ff      <= '0;
      drive_ff     <= 1'b0;
    end else begin
      op1_ff       <= nxt_op1;
      pipe_data_ff <= nxt_pipe_data;
      dout_ff      <= nxt_dout;
      drive_ff     <= nxt_drive;
    end
  end

  // The enable gating uses the raw pins on purpose: output enable and sleep
  // must float the bus without waiting for a clock edge. This path is purely
  // combinational, so no sampling hazard arises from skipping the synchronizer.
  always_comb begin
    DQ_OUT  = dout_ff;
    DQ_OE_N = !(drive_ff && !OUT_EN_N && !SLEEP_REQ);
  end

endmodule : sync_burst_sram_core

// file: tb/sram_chk.sv
// Output drive timing checker for the burst SRAM core.
`timescale 1ns/1ps
module sram_chk #(
  parameter int DATA_W = 18
) (
  input wire logic              CLK,
  input wire logic              RST_N,
  input wire logic [DATA_W-1:0] DQ_OUT,
  input wire logic              DQ_OE_N,
  input wire logic              CHIP_SEL1_N,
  input wire logic              CHIP_SEL2,
  input wire logic              CHIP_SEL3_N,
  input wire logic              PROC_ADDR_STROBE_N,
  input wire logic              CTRL_ADDR_STROBE_N,
  input wire logic              ALL_BYTES_WRITE_N,
  input wire logic              BYTE_WRITE_EN_N,
  input wire logic              OUT_EN_N,
  input wire logic              SLEEP_REQ,
  input wire logic              FLOWTHROUGH_SEL_N,
  input wire logic              DESELECT_MODE_SEL
);
  logic [1:0] calm_ff, nxt_calm, mode_ff;
  logic       cs_ok, quiet, on_ok, settled, rd_go, dsl_go, wr_go;
  assign cs_ok   = !CHIP_SEL1_N & CHIP_SEL2 & !CHIP_SEL3_N;
  assign quiet   = PROC_ADDR_STROBE_N & CTRL_ADDR_STROBE_N & ALL_BYTES_WRITE_N & BYTE_WRITE_EN_N;
  assign on_ok   = OUT_EN_N | SLEEP_REQ | !DQ_OE_N;
  assign settled = calm_ff == 2'h3;
  assign rd_go   = settled & cs_ok & !PROC_ADDR_STROBE_N;
  assign dsl_go  = settled & !cs_ok & !CTRL_ADDR_STROBE_N;
  assign wr_go   = settled & cs_ok & !CTRL_ADDR_STROBE_N & !ALL_BYTES_WRITE_N;
  // Straps and sleep pass a two-stage sync, so checks wait until both have been quiet.
  always_comb begin
    nxt_calm = (calm_ff == 2'h3) ? calm_ff : calm_ff + 2'h1;
    if (SLEEP_REQ || mode_ff != {FLOWTHROUGH_SEL_N, DESELECT_MODE_SEL}) nxt_calm = 2'h0;
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      calm_ff <= 2'h0;
      mode_ff <= 2'h3;
    end else begin
      calm_ff <= nxt_calm;
      mode_ff <= {FLOWTHROUGH_SEL_N, DESELECT_MODE_SEL};
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  property p_oe_async; (OUT_EN_N || SLEEP_REQ) |-> DQ_OE_N; endproperty
  a_oe_async: assert property (p_oe_async) else $error("drive while disabled");
  property p_flow; rd_go && !FLOWTHROUGH_SEL_N |=> on_ok; endproperty
  a_flow: assert property (p_flow) else $error("flow read late");
  property p_pipe; rd_go && FLOWTHROUGH_SEL_N ##1 quiet |=> on_ok; endproperty
  a_pipe: assert property (p_pipe) else $error("pipelined read late");
  property p_scd; dsl_go && DESELECT_MODE_SEL && !FLOWTHROUGH_SEL_N |=> DQ_OE_N; endproperty
  a_scd: assert property (p_scd) else $error("single deselect slow");
  property p_dcd_hold; dsl_go && !DESELECT_MODE_SEL && !DQ_OE_N |=> on_ok; endproperty
  a_dcd_hold: assert property (p_dcd_hold) else $error("dual deselect early");
  property p_dcd_off; dsl_go ##1 PROC_ADDR_STROBE_N && CTRL_ADDR_STROBE_N |=> DQ_OE_N; endproperty
  a_dcd_off: assert property (p_dcd_off) else $error("deselect never off");
  // A pipelined read that is due at the write edge may still show for one cycle,
  // so the turn-off is checked once a second write cycle has also been captured.
  property p_wr_off;
    wr_go ##1 (!ALL_BYTES_WRITE_N && PROC_ADDR_STROBE_N && cs_ok) |=> DQ_OE_N;
  endproperty
  a_wr_off: assert property (p_wr_off) else $error("drive during write");
  property p_sleep; SLEEP_REQ [*4] |=> $stable(DQ_OUT); endproperty
  a_sleep: assert property (p_sleep) else $error("data moved in sleep");
  c_rd: cover property (rd_go);
  c_dsl: cover property (dsl_go);
  c_wr: cover property (wr_go);
endmodule : sram_chk
bind sync_burst_sram_core sram_chk #(.DATA_W(DATA_W)) u_chk (.*);

// file: tb/bus_master.sv
// Bus master model: one command per clock, launched on the falling edge.
`timescale 1ns/1ps
module bus_master (
  input wire logic    clk,
  output logic [7:0]  ctl  = 8'h5F,
  output logic [20:0] addr = 21'h0,
  output logic [17:0] dq   = 18'h0,
  output logic [1:0]  ln   = 2'h3
);
  // Bits: select 1, 2, 3, processor strobe, controller strobe, advance, byte write, global.
  localparam logic [7:0] CODE [8] = '{8'h5F, 8'h4F, 8'h56, 8'h55, 8'h5B, 8'h5A, 8'h17, 8'hCF};
  task automatic cmd(input int k, input logic [20:0] a, input logic [17:0] d, input logic [1:0] l);
    @(negedge clk);
    ctl  <= CODE[k];
    // Address and data lines with no meaning this cycle toggle, so a stale value never passes for a fresh one.
    addr <= (k inside {1, 2, 3, 6, 7}) ? a : ~addr;
    dq   <= (k inside {2, 3, 5}) ? d : ~dq;
    ln   <= l;
  endtask : cmd
endmodule : bus_master

// file: tb/sync_burst_sram_core_test.sv
// Self-checking bench for the burst SRAM core against an associative-array memory model.
`timescale 1ns/1ps
module sync_burst_sram_core_test;
  logic        clk, rst_n, oe_n, sleep, lin_n, ft_n, dsl, dq_oe_n;
  logic [7:0]  ctl;
  logic [20:0] addr;
  logic [17:0] dq, dq_out, d, mem [int], eq [$];
  logic [1:0]  ln;
  int          cyc, base, n, a, num_errors, total_checks, due [$];
  bus_master m (.clk(clk), .ctl(ctl), .addr(addr), .dq(dq), .ln(ln));
  sync_burst_sram_core uut (
    .CLK(clk), .RST_N(rst_n), .ADDR(addr), .DQ_IN(dq), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n),
    .CHIP_SEL1_N(ctl[7]), .CHIP_SEL2(ctl[6]), .CHIP_SEL3_N(ctl[5]),
    .PROC_ADDR_STROBE_N(ctl[4]), .CTRL_ADDR_STROBE_N(ctl[3]), .BURST_ADVANCE_N(ctl[2]),
    .BYTE_WRITE_EN_N(ctl[1]), .ALL_BYTES_WRITE_N(ctl[0]), .BYTE_LANE_SEL_N(ln),
    .OUT_EN_N(oe_n), .SLEEP_REQ(sleep), .LINEAR_ORDER_SEL_N(lin_n),
    .FLOWTHROUGH_SEL_N(ft_n), .DESELECT_MODE_SEL(dsl));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic go(input int k, input int ad, input logic [1:0] l);
    logic [20:0] ea;
    d = 18'($urandom);
    m.cmd(k, 21'(ad), d, l);
    if (k inside {1, 2, 3}) begin
      base = ad;
      n = 0;
    end
    if (k inside {4, 5}) n++;
    ea = 21'(base);
    ea[1:0] = lin_n ? ea[1:0] ^ 2'(n) : ea[1:0] + 2'(n);
    if (k inside {2, 5}) mem[ea] = d;
    if (k == 3) for (int i = 0; i < 2; i++) if (!l[i]) mem[ea][9*i+:9] = d[9*i+:9];
    if (k inside {1, 4}) begin
      eq.push_back(mem[ea]);
      due.push_back(cyc + (ft_n ? 2 : 1));
    end
  endtask : go
  // Each read result is due at its capture edge in flow mode, one edge later when pipelined.
  always @(negedge clk) begin
    if (due.size() > 0 && due[0] == cyc) begin
      chk(dq_out, eq.pop_front());
      void'(due.pop_front());
    end
  end
  initial begin
    {rst_n, oe_n, sleep, lin_n, ft_n, dsl} = 6'h07;
    void'($urandom(72751));
    repeat (4) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    for (int md = 0; md < 4; md++) begin
      {ft_n, lin_n} = 2'(md);
      a = $urandom & 32'h1FFFFF;
      repeat (4) go(0, 0, 2'h3);
      go(2, a, 2'(md));
      repeat (3) go(5, 0, 2'h3);
      go(1, a, 2'h3);
      go(4, 0, 2'h3);
      go(7, ~a, 2'h3);
      repeat (2) go(4, 0, 2'h3);
      go(3, a, 2'h2);
      go(1, a, 2'h3);
      go(1, a ^ 2, 2'h3);
      repeat (3) go(0, 0, 2'h3);
    end
    oe_n = 1'b1;
    #1 chk(dq_oe_n, 1'b1);
    oe_n = 1'b0;
    #1 chk(dq_oe_n, 1'b0);
    sleep = 1'b1;
    #1 chk(dq_oe_n, 1'b1);
    repeat (4) go(0, 0, 2'h3);
    m.cmd(2, 21'(a), ~mem[a], 2'h0);
    repeat (3) go(0, 0, 2'h3);
    sleep = 1'b0;
    repeat (4) go(0, 0, 2'h3);
    go(1, a, 2'h3);
    for (int s = 0; s < 2; s++) begin
      {ft_n, dsl} = {1'b0, 1'(s)};
      repeat (4) go(0, 0, 2'h3);
      go(1, a, 2'h3);
      go(6, a, 2'h3);
      go(0, 0, 2'h3);
      chk(dq_oe_n, dsl);
      go(0, 0, 2'h3);
      chk(dq_oe_n, 1'b1);
    end
    tally_and_finish();
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule : sync_burst_sram_core_test
